// File: inc/cedc_cfg.svh
// Constants of the extended display control block: port addresses, index,
// bit positions and reset values.
// Assumes it is included by its bare name from the package and the design file.
`ifndef CEDC_CFG_SVH
`define CEDC_CFG_SVH

// I/O port addresses of the indexed controller port.
`define CEDC_PORT_INDEX      16'h03d4
`define CEDC_PORT_DATA       16'h03d5

// Index of the extended display control register and its reset value.
`define CEDC_IDX_EXT_CTL     8'h1b
`define CEDC_EXT_CTL_RESET   8'h00
`define CEDC_INDEX_RESET     8'h00

// Bit positions inside the extended display control register.
`define CEDC_BIT_BLANK_EXT   7
`define CEDC_BIT_FAST_PAGE   6
`define CEDC_BIT_BLANK_SRC   5
`define CEDC_BIT_OFFSET_8    4
`define CEDC_BIT_START_18    3
`define CEDC_BIT_START_17    2
`define CEDC_BIT_EXT_WRAP    1
`define CEDC_BIT_START_16    0

// Field positions inside the misc display control register.
`define CEDC_MISC_VBE_HI     7:6
`define CEDC_MISC_HBE_HI     5:4

// Address widths.
`define CEDC_VGA_ADDR_W      16
`define CEDC_EXT_ADDR_W      19

`endif

// File: inc/cedc_pkg.sv
// Types of the extended display control block.
// Assumes cedc_cfg.svh is on the include path.
`default_nettype none
`include "cedc_cfg.svh"

package cedc_pkg;
  typedef logic [7:0]                     cedc_byte_t;
  typedef logic [`CEDC_EXT_ADDR_W-1:0]    cedc_addr_t;

  typedef struct packed {
    cedc_byte_t  ext_ctl;
    cedc_byte_t  index;
    cedc_byte_t  rdata;
    logic [9:0]  vblank_end;
    logic [7:0]  hblank_end;
    logic [8:0]  row_offset;
    cedc_addr_t  start_addr;
    cedc_addr_t  crt_dram_addr;
    cedc_addr_t  host_dram_addr;
    logic        fast_page;
    logic        dac_blank;
    logic        overlay_window_n;
  } cedc_state_t;
endpackage : cedc_pkg
`default_nettype wire

// File: rtl/cedc_ext_display.sv
// Extended display control register of the CRT timing controller and the
// address, blanking and overflow logic that it steers.
// Assumes all inputs come from logic on the video clock, including the I/O port strobes.
`timescale 1ns/100ps
`default_nettype none
`include "cedc_cfg.svh"

// What this block does
// RL1: Blank-end extension bits apply only if extension-enable or blanking-source is set.
// RL2: Extension-enable set honours the blank-end extension bits regardless of blanking-source.
// RL3: Fast-page bit clear makes every font fetch a random read; keep clear for dual font.
// RL4: Fast-page bit set fetches font data with fast-page cycles for faster text clocks.
// RL5: Blanking-source clear blanks the palette DAC from the controller blank signal.
// RL6: Blanking-source set blanks the palette DAC from display enable, hiding the border.
// RL7: Blanking-source set drives the overlay window pin from the internal blank signal.
// RL8: Bit 4 is bit 8 of the row offset value.
// RL9: Bits 3 and 2 are display start address bits 18 and 17.
// RL10: Extended-wrap clear wraps display memory at 64K per map, 256K total.
// RL11: Extended-wrap set lets display addresses run over all installed memory.
// RL12: Wrap with chain-4 maps address bits 16,17 to DRAM A0,A1; adds offset above 12.
// RL13: Wrap with doubleword maps controller address bits 14,15 to DRAM A0,A1.
// RL14: Character address counter is 16 bits with wrap clear, 19 bits with it set.
// RL15: Bit 0 is display start address bit 16.
// RL16: Enabled vertical extension bits widen vertical blank end to ten bits.
// RL17: Enabled horizontal extension bits widen horizontal blank end to eight bits.
// RL18: A read returns the eight bits last written, all fields read-write.
module cedc_ext_display
  import cedc_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Indexed I/O port.
  input  wire logic [15:0]           io_addr_i,
  input  wire logic                  io_wr_i,
  input  wire logic                  io_rd_i,
  input  wire logic [7:0]            io_wdata_i,
  output logic      [7:0]            io_rdata_o,
  // Other controller registers.
  input  wire logic [7:0]            misc_display_control_i,
  input  wire logic [7:0]            row_offset_register_i,
  input  wire logic [7:0]            vblank_end_lo_i,
  input  wire logic [5:0]            hblank_end_lo_i,
  input  wire logic [15:0]           start_addr_lo_i,
  input  wire logic                  dword_mode_i,
  input  wire logic                  chain4_mode_i,
  input  wire logic [6:0]            host_offset_i,
  input  wire logic [18:0]           mem_mask_i,
  // Timing and address sources.
  input  wire logic                  timing_blank_i,
  input  wire logic                  display_enable_i,
  input  wire logic [18:0]           char_counter_address_i,
  input  wire logic [16:0]           host_extended_address_i,
  // Derived timing values.
  output logic      [9:0]            vblank_end_o,
  output logic      [7:0]            hblank_end_o,
  output logic      [8:0]            row_offset_o,
  output logic      [18:0]           start_addr_o,
  // Memory addressing.
  output logic      [18:0]           crt_dram_addr_o,
  output logic      [18:0]           host_dram_addr_o,
  output logic                       fast_page_font_o,
  // Palette DAC and overlay.
  output logic                       dac_blank_o,
  output logic                       overlay_window_pin_n_o
);
  import cedc_pkg::*;

  cedc_state_t state;
  cedc_state_t next_state;

  logic        ext_wrap;
  logic        blank_src;
  logic        blank_ext_on;
  logic [18:0] char_addr;
  logic [18:0] ext_mem_addr;
  logic [6:0]  ext_mem_addr_hi;

  // Limits an address to a 64K map unless extended wrap is on, then to installed memory.
  function automatic logic [18:0] cedc_wrap(input logic [18:0] addr,
                                            input logic        wrap,
                                            input logic [18:0] mask);
    logic [18:0] res;
    res = wrap ? (addr & mask) : {3'h0, addr[15:0]};
    return res;
  endfunction : cedc_wrap

  // Decodes an access to the data port aimed at this register.
  function automatic logic cedc_hit(input logic [15:0] addr,
                                    input logic [7:0]  idx);
    logic res;
    res = (addr == `CEDC_PORT_DATA) && (idx == `CEDC_IDX_EXT_CTL);
    return res;
  endfunction : cedc_hit

  // Doubleword remap: controller address bits 15 and 14 drive DRAM A1 and A0.
  function automatic logic [18:0] cedc_dword_map(input logic [18:0] addr);
    logic [18:0] res;
    res = {addr[18:16], addr[13:0], addr[15:14]};
    return res;
  endfunction : cedc_dword_map

  // Chain-4 remap: extended address bits 17 and 16 drive DRAM A1 and A0.
  function automatic logic [18:0] cedc_chain4_map(input logic [18:0] addr);
    logic [18:0] res;
    res = {addr[18], addr[15:0], addr[17:16]};
    return res;
  endfunction : cedc_chain4_map

  always_comb
  begin
    next_state = state;
    ext_wrap = state.ext_ctl[`CEDC_BIT_EXT_WRAP];
    blank_src = state.ext_ctl[`CEDC_BIT_BLANK_SRC];
    blank_ext_on = state.ext_ctl[`CEDC_BIT_BLANK_EXT] | blank_src; // see RL1, see RL2

    // Register port.
    // The index latch selects which register the data port reaches.
    if (io_wr_i && io_addr_i == `CEDC_PORT_INDEX)
    begin
      next_state.index = io_wdata_i;
    end
    if (io_wr_i && cedc_hit(io_addr_i, state.index))
    begin
      next_state.ext_ctl = io_wdata_i; // see RL18
    end
    if (io_rd_i)
    begin
      if (io_addr_i == `CEDC_PORT_INDEX)
      begin
        next_state.rdata = state.index;
      end
      else if (cedc_hit(io_addr_i, state.index))
      begin
        next_state.rdata = state.ext_ctl; // see RL18
      end
      else
      begin
        // Reads that hit no register return zero rather than stale data.
        next_state.rdata = 8'h00;
      end
    end

    // Blank-end extensions.
    // Disabled extension bits read as zero, so the low fields alone set the end value.
    next_state.vblank_end = {blank_ext_on ? misc_display_control_i[`CEDC_MISC_VBE_HI] : 2'h0,
                             vblank_end_lo_i}; // see RL16
    next_state.hblank_end = {blank_ext_on ? misc_display_control_i[`CEDC_MISC_HBE_HI] : 2'h0,
                             hblank_end_lo_i}; // see RL17

    // Offset and start address overflow bits.
    next_state.row_offset = {state.ext_ctl[`CEDC_BIT_OFFSET_8], row_offset_register_i}; // see RL8
    next_state.start_addr = {state.ext_ctl[`CEDC_BIT_START_18],
                             state.ext_ctl[`CEDC_BIT_START_17], // see RL9
                             state.ext_ctl[`CEDC_BIT_START_16], // see RL15
                             start_addr_lo_i};

    // Font fetch cycle type.
    next_state.fast_page = state.ext_ctl[`CEDC_BIT_FAST_PAGE]; // see RL3, see RL4

    // Palette DAC blanking and overlay window.
    if (blank_src)
    begin
      next_state.dac_blank = ~display_enable_i; // see RL6
      next_state.overlay_window_n = ~timing_blank_i; // see RL7
    end
    else
    begin
      next_state.dac_blank = timing_blank_i; // see RL5
      // With blanking-source clear the overlay pin stays inactive.
      next_state.overlay_window_n = 1'b1;
    end

    // Display address path.
    // Without extended wrap the doubleword remap stays off, keeping the linear VGA map.
    char_addr = cedc_wrap(char_counter_address_i, ext_wrap, mem_mask_i); // see RL10, RL11, RL14
    if (ext_wrap && dword_mode_i)
    begin
      next_state.crt_dram_addr = cedc_dword_map(char_addr); // see RL13
    end
    else
    begin
      next_state.crt_dram_addr = char_addr;
    end

    // Host address path.
    // The offset sum only feeds the chain-4 path; other host accesses use the plain address.
    ext_mem_addr_hi = 7'(host_extended_address_i[16:12]) + host_offset_i; // see RL12
    ext_mem_addr = {ext_mem_addr_hi, host_extended_address_i[11:0]};
    if (ext_wrap && chain4_mode_i)
    begin
      next_state.host_dram_addr = cedc_chain4_map(ext_mem_addr); // see RL12
    end
    else
    begin
      next_state.host_dram_addr = cedc_wrap({2'h0, host_extended_address_i}, ext_wrap,
                                            mem_mask_i); // see RL10, RL11
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= '0;
      state.ext_ctl <= `CEDC_EXT_CTL_RESET;
      state.index <= `CEDC_INDEX_RESET;
      // The overlay pin is active low, so it idles high through reset.
      state.overlay_window_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Every output comes straight from a flop, so no decode glitch reaches a pin.
  assign io_rdata_o             = state.rdata;
  assign vblank_end_o           = state.vblank_end;
  assign hblank_end_o           = state.hblank_end;
  assign row_offset_o           = state.row_offset;
  assign start_addr_o           = state.start_addr;
  assign crt_dram_addr_o        = state.crt_dram_addr;
  assign host_dram_addr_o       = state.host_dram_addr;
  assign fast_page_font_o       = state.fast_page;
  assign dac_blank_o            = state.dac_blank;
  assign overlay_window_pin_n_o = state.overlay_window_n;

endmodule : cedc_ext_display
`default_nettype wire

// File: sim/cedc_ext_display_chk.sv
// Checker of the extended display control register and the outputs it steers.
// Assumes it is bound to the top module and sees its ports on the one video clock.
`timescale 1ns/100ps
`default_nettype none
module cedc_ext_display_chk (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register port.
  input wire logic        io_wr_i,
  input wire logic        io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0]  io_wdata_i,
  input wire logic [7:0]  io_rdata_o,
  // Controller inputs.
  input wire logic        dword_mode_i,
  input wire logic        timing_blank_i,
  input wire logic        display_enable_i,
  input wire logic [15:0] start_addr_lo_i,
  input wire logic [7:0]  misc_display_control_i,
  input wire logic [7:0]  row_offset_register_i,
  input wire logic [7:0]  vblank_end_lo_i,
  input wire logic [18:0] char_counter_address_i,
  // Outputs watched.
  input wire logic [18:0] start_addr_o,
  input wire logic [18:0] crt_dram_addr_o,
  input wire logic [9:0]  vblank_end_o,
  input wire logic [8:0]  row_offset_o,
  input wire logic        fast_page_font_o,
  input wire logic        dac_blank_o,
  input wire logic        overlay_window_pin_n_o
);
  logic [7:0] idx, r;
  logic       live;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      idx  <= 8'h00;
      r    <= 8'h00;
      live <= 1'b0;
    end
    else
    begin
      live <= 1'b1;
      if (io_wr_i && io_addr_i == 16'h03d4)
        idx <= io_wdata_i;
      if (io_wr_i && io_addr_i == 16'h03d5 && idx == 8'h1b)
        r <= io_wdata_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_dac_blank_src: assert property (live |-> dac_blank_o ==
    ($past(r[5]) ? !$past(display_enable_i) : $past(timing_blank_i))) else $error("dac blank");
  a_overlay_pin_follow: assert property (live |-> overlay_window_pin_n_o ==
    ($past(r[5]) ? !$past(timing_blank_i) : 1'b1)) else $error("overlay pin");
  a_row_offset_high: assert property (live |-> row_offset_o ==
    {$past(r[4]), $past(row_offset_register_i)}) else $error("row offset");
  a_start_addr_high: assert property (live |-> start_addr_o[18:16] ==
    {$past(r[3:2]), $past(r[0])}) else $error("start address");
  a_vblank_ext_gate: assert property (live |-> vblank_end_o == {($past(r[7]) ||
    $past(r[5])) ? $past(misc_display_control_i[7:6]) : 2'b00, $past(vblank_end_lo_i)})
    else $error("vertical blank end");
  a_fast_page_font: assert property (live |-> fast_page_font_o == $past(r[6]))
    else $error("font fetch mode");
  a_read_back_value: assert property (io_rd_i && io_addr_i == 16'h03d5 && idx == 8'h1b
    |=> io_rdata_o == $past(r)) else $error("read back");
  a_vga_wrap_clear: assert property (live && !$past(r[1]) |-> crt_dram_addr_o ==
    {3'b000, $past(char_counter_address_i[15:0])}) else $error("vga wrap");
  c_overlay_active: cover property (live && $past(r[5]) && !overlay_window_pin_n_o);
  c_data_read: cover property (io_rd_i && io_addr_i == 16'h03d5);
  c_dword_wrap: cover property (live && $past(r[1]) && $past(dword_mode_i));
endmodule : cedc_ext_display_chk
bind cedc_ext_display cedc_ext_display_chk chk (.*);
`default_nettype wire

// File: sim/cedc_mem_dac_model.sv
// Model of the timing side seen by the palette DAC: blank and display enable.
// Assumes the bench clock; levels change just after each rising edge.
`timescale 1ns/100ps
`default_nettype none
module cedc_mem_dac_model (
  input  wire logic clk_i,
  output logic      timing_blank_o,
  output logic      display_enable_o
);
  logic [3:0] beat = 4'h0;
  always @(posedge clk_i)
    beat <= #1 beat + 4'h1;
  // A border gap sits between display enable and blank.
  assign display_enable_o = beat < 4'ha;
  assign timing_blank_o   = beat > 4'hb;
endmodule : cedc_mem_dac_model
`default_nettype wire

// File: sim/cedc_ext_display_bench.sv
// Self-checking bench of the extended display control block.
// Assumes the package, the design and the sim models are compiled first.
`timescale 1ns/100ps
`default_nettype none
module cedc_ext_display_bench;
  logic        clk_i = 1'b0, rst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0;
  logic        dword_mode_i = 1'b0, chain4_mode_i = 1'b1, timing_blank_i, display_enable_i;
  logic [15:0] io_addr_i = 16'h0000, start_addr_lo_i = 16'hbeef;
  logic [7:0]  io_wdata_i = 8'h00, misc_display_control_i = 8'hf0, io_rdata_o, v;
  logic [7:0]  row_offset_register_i = 8'h9c, vblank_end_lo_i = 8'h3e, hblank_end_o;
  logic [5:0]  hblank_end_lo_i = 6'h2a;
  logic [6:0]  host_offset_i = 7'h55;
  logic [18:0] mem_mask_i = 19'h1ffff, char_counter_address_i = 19'h2b5c3, ext_addr;
  logic [18:0] start_addr_o, crt_dram_addr_o, host_dram_addr_o, cnt_addr;
  logic [16:0] host_extended_address_i = 17'h1d7a9;
  logic [9:0]  vblank_end_o;
  logic [8:0]  row_offset_o;
  logic        fast_page_font_o, dac_blank_o, overlay_window_pin_n_o;
  int          fail_count = 0, samples_checked = 0;
  logic [7:0]  vals [6] = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h22, 8'h80};
  cedc_ext_display uut (.*);
  cedc_mem_dac_model dac (.clk_i(clk_i), .timing_blank_o(timing_blank_i),
                          .display_enable_o(display_enable_i));
  always #20 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [18:0] e, input logic [18:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] d);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = !rd;
    io_rd_i = rd;
    @(posedge clk_i);
    #1;
  endtask : acc
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk("overlay pin", 19'h1, overlay_window_pin_n_o);
    acc(0, 16'h03d4, 8'h1b);
    acc(1, 16'h03d5, 8'h00);
    chk("reset value", 19'h0, io_rdata_o);
    foreach (vals[i])
    begin
      v = vals[i];
      dword_mode_i = i[0];
      chain4_mode_i = !i[0];
      mem_mask_i = i[0] ? 19'h7ffff : 19'h1ffff;
      acc(0, 16'h03d5, v);
      acc(0, 16'h03d6, 8'h00);
      acc(0, 16'h03d6, 8'h00);
      acc(1, 16'h03d5, 8'h00);
      chk("readback", v, io_rdata_o);
      chk("start", {v[3:2], v[0], start_addr_lo_i}, start_addr_o);
      chk("row offset", {v[4], row_offset_register_i}, row_offset_o);
      chk("fast page", v[6], fast_page_font_o);
      chk("vblank", {(v[7] | v[5]) ? misc_display_control_i[7:6] : 2'b00, vblank_end_lo_i},
          vblank_end_o);
      chk("hblank", {(v[7] | v[5]) ? misc_display_control_i[5:4] : 2'b00, hblank_end_lo_i},
          hblank_end_o);
      cnt_addr = char_counter_address_i;
      chk("crt addr", !v[1] ? {3'b000, cnt_addr[15:0]} : dword_mode_i ?
          {cnt_addr[18:16], cnt_addr[13:0], cnt_addr[15:14]} : cnt_addr & mem_mask_i,
          crt_dram_addr_o);
      ext_addr = {host_extended_address_i[16:12] + host_offset_i, host_extended_address_i[11:0]};
      chk("host addr", !v[1] ? {3'b000, host_extended_address_i[15:0]} :
          chain4_mode_i ? {ext_addr[18], ext_addr[15:0], ext_addr[17:16]}
          : {2'b00, host_extended_address_i} & mem_mask_i, host_dram_addr_o);
    end
    acc(0, 16'h03d4, 8'h1a);
    acc(0, 16'h03d5, 8'h77);
    acc(1, 16'h03d5, 8'h00);
    chk("other index", 19'h0, io_rdata_o);
    acc(0, 16'h03d4, 8'h1b);
    acc(1, 16'h03d5, 8'h00);
    chk("kept value", 19'h80, io_rdata_o);
    acc(1, 16'h03d6, 8'h00);
    chk("unmapped", 19'h0, io_rdata_o);
    acc(1, 16'h03d4, 8'h00);
    chk("index read", 19'h1b, io_rdata_o);
    tally_and_finish();
  end
endmodule : cedc_ext_display_bench
`default_nettype wire
